// File: design/arinc_rx_pkg.sv
// Shared constants and types for the dual serial receiver block.
package arinc_rx_pkg;

  // ==========================================================================
  // Widths and layout
  // ==========================================================================
  localparam int BUS_W = 16;
  localparam int WORD_BITS = 32;
  localparam int OPT_W = 10;
  // Bus line that carries the lowest option bit.
  localparam int OPT_LSB = 5;
  localparam int LABEL_BIT9_IDX = 8;
  localparam int LABEL_BIT10_IDX = 9;
  localparam int PARITY_IDX = 31;
  // Option reset value: loopback off, filters off, fast rates, odd parity.
  localparam logic [9:0] OPTION_RESET = 10'h001;

  // ==========================================================================
  // Receiver timing, in samples and master clocks
  // ==========================================================================
  localparam int SR_W = 10;
  localparam int SETTLE = 3;
  localparam int SPACE_MIN = 8;
  localparam int SPACE_MAX = 12;
  localparam int GAP_NULLS = 3;
  localparam int SAMPLES_PER_BIT = 10;
  localparam int DATA_DIV_FAST = 10;
  localparam int DATA_DIV_SLOW = 80;
  localparam int SAMPLE_DIV_FAST = DATA_DIV_FAST / SAMPLES_PER_BIT;
  localparam int SAMPLE_DIV_SLOW = DATA_DIV_SLOW / SAMPLES_PER_BIT;
  localparam int TX_HALF_FAST = DATA_DIV_FAST / 2;
  localparam int TX_HALF_SLOW = DATA_DIV_SLOW / 2;
  localparam int FIFO_DEPTH = 16;

  // ==========================================================================
  // Types
  // ==========================================================================
  // Option word, most significant field first; loopback_n sits on bit 0.
  typedef struct packed {
    logic rx_rate_select;
    logic tx_rate_select;
    logic parity_sense_bit;
    logic rx_two_label_bit10;
    logic rx_two_label_bit9;
    logic rx_two_filter_enable;
    logic rx_one_label_bit10;
    logic rx_one_label_bit9;
    logic rx_one_filter_enable;
    logic loopback_test_bit;
  } option_t;

  // Comparator levels of one receiver input.
  typedef struct packed {
    logic one_lvl;
    logic zero_lvl;
  } line_t;

  // Accepted word tagged with its receiver.
  typedef struct packed {
    logic id;
    logic [WORD_BITS-1:0] data;
  } rx_word_t;

  localparam int FIFO_W = $bits(rx_word_t);

endpackage

// File: design/word_fifo.sv
// Synchronous valid/ready FIFO with parameterised width and depth.
module word_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // ==========================================================================
  // Flags and pointer update
  // ==========================================================================
  assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = mem[s_q.rd];
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      s_d = '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_q.wr] <= in_data;
    end
  end

endmodule

// File: design/arinc_dual_rx.sv
// Dual serial receiver with option word, word holding buffers and host bus.

// Behaviour
// [R1] Ten option bits captured on option strobe.
// [R2] Loopback bit zero feeds transmitter into receivers.
// [R3] Receiver one filter: bits 9,10 match options.
// [R4] Receiver two filter: bits 9,10 match options.
// [R5] Parity sense: zero odd, one even.
// [R6] Transmit clock is master divided 10/80.
// [R7] Receive clock is master divided 10/80.
// [R8] Serial bit 1 arrives first, then ascending.
// [R9] Bus halves follow the fixed bit mapping.
// [R10] Ten-bit samplers; three matching samples validate.
// [R11] Bit needs one/zero then null.
// [R12] Word gap needs three nulls both halves.
// [R13] Bit spacing must be 8 to 12.
// [R14] Gap timer counts three nulls, then re-arm.
// [R15] Bit 32 replaced by parity flag.
// [R16] End-of-word event; accepted word lowers ready.
// [R17] Ready stays low until both halves read.
// [R18] Strobe one reads receiver one, two two.
// [R19] New word overwrites an unread held word.
// [R20] Loopback: receiver two gets complemented data.
// [R21] Master reset clears words, flags, keeps options.
// [R22] Receiver two drives only while strobe one high.
// [R23] One holding word per receiver, read independently.
// [R24] Ten samples per receive data clock period.
module arinc_dual_rx #(
  parameter int DEPTH = arinc_rx_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic master_reset_n,
  input wire logic option_word_strobe,
  input wire logic [arinc_rx_pkg::BUS_W-1:0] bus_in,
  output logic [arinc_rx_pkg::BUS_W-1:0] bus_out,
  output logic bus_oe,
  input wire logic byte_select,
  input wire logic rx_one_read_strobe_n,
  input wire logic rx_two_read_strobe_n,
  output logic rx_one_word_ready_n,
  output logic rx_two_word_ready_n,
  output logic [1:0] word_complete_event,
  input wire arinc_rx_pkg::line_t rx_one_line,
  input wire arinc_rx_pkg::line_t rx_two_line,
  input wire arinc_rx_pkg::line_t tx_serial_line_out,
  output logic tx_data_clk,
  output logic tx_parity_even
);
  import arinc_rx_pkg::*;

  typedef enum logic [1:0] {
    RX_WAIT_GAP,
    RX_BITS,
    RX_GAP_TIMER
  } rx_phase_t;

  typedef struct packed {
    rx_phase_t phase;
    logic [SR_W-1:0] one_sr;
    logic [SR_W-1:0] zero_sr;
    logic [SR_W-1:0] null_sr;
    logic [5:0] bit_cnt;
    logic [WORD_BITS-1:0] shift;
    logic [4:0] space_cnt;
    logic [6:0] gap_div;
    logic [1:0] gap_nulls;
  } rx_state_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] word;
    logic ready_n;
    logic [1:0] halves;
    logic strobe_low;
    logic sel_seen;
  } hold_t;

  typedef struct packed {
    option_t opt;
    rx_state_t [1:0] rx;
    logic [2:0] sample_div;
    logic [6:0] tx_div;
    logic tx_clk;
    logic [1:0] event_pulse;
    logic [1:0] pend_v;
    logic [1:0][WORD_BITS-1:0] pend_w;
    hold_t [1:0] hold;
    logic [BUS_W-1:0] bus_out;
    logic bus_oe;
  } core_t;

  core_t s_q;
  core_t s_d;
  line_t [1:0] line_in;
  logic [1:0] strobe_low;
  logic fifo_in_valid;
  logic fifo_in_ready;
  rx_word_t fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  rx_word_t fifo_out_data;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Arranges one half of a held word onto the bus lines.
  function automatic logic [BUS_W-1:0] bus_half(input logic [WORD_BITS-1:0] w, input logic second);
    logic [BUS_W-1:0] h;
    h = '0;
    if (second) begin
      h = w[28:13]; // [R9]
    end else begin
      h[15:11] = w[12:8]; // [R9]
      h[10] = w[30];
      h[9] = w[29];
      h[8] = w[PARITY_IDX];
      for (int i = 0; i < 8; i++) begin
        h[7-i] = w[i];
      end
    end
    return h;
  endfunction

  // True when the top or bottom three samples of a sampler are all set.
  function automatic logic top_settled(input logic [SR_W-1:0] sr);
    return &sr[SR_W-1 -: SETTLE];
  endfunction

  function automatic logic low_settled(input logic [SR_W-1:0] sr);
    return &sr[SETTLE-1:0];
  endfunction

  // ==========================================================================
  // Input selection and read strobes
  // ==========================================================================
  always_comb begin
    if (s_q.opt.loopback_test_bit) begin
      line_in[0] = rx_one_line;
      line_in[1] = rx_two_line;
    end else begin
      line_in[0] = tx_serial_line_out; // [R2]
      line_in[1].one_lvl = tx_serial_line_out.zero_lvl; // [R20]
      line_in[1].zero_lvl = tx_serial_line_out.one_lvl;
    end
  end

  assign strobe_low[0] = !rx_one_read_strobe_n; // [R18]
  assign strobe_low[1] = !rx_two_read_strobe_n && rx_one_read_strobe_n; // [R22]

  // ==========================================================================
  // Word buffer between receivers and holding words
  // ==========================================================================
  assign fifo_in_valid = |s_q.pend_v;
  assign fifo_in_data.id = !s_q.pend_v[0];
  assign fifo_in_data.data = s_q.pend_v[0] ? s_q.pend_w[0] : s_q.pend_w[1];
  // A holding word is never replaced while its receiver is being read.
  assign fifo_out_ready = !strobe_low[fifo_out_data.id];

  word_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .flush(!master_reset_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    logic tick;
    logic hi_one;
    logic hi_zero;
    logic lo_null;
    logic gap_null;
    logic bit_ok;
    logic accept;
    logic done;
    logic [WORD_BITS-1:0] w;
    tick = 1'b0;
    hi_one = 1'b0;
    hi_zero = 1'b0;
    lo_null = 1'b0;
    gap_null = 1'b0;
    bit_ok = 1'b0;
    accept = 1'b0;
    done = 1'b0;
    w = '0;
    s_d = s_q;
    s_d.event_pulse = '0;

    if (option_word_strobe) begin
      s_d.opt = option_t'(bus_in[OPT_LSB +: OPT_W]); // [R1]
    end

    // Transmit data clock: toggles every half period of 10 or 80 clocks.
    if (s_q.tx_div == '0) begin
      s_d.tx_div = s_q.opt.tx_rate_select ? 7'(TX_HALF_SLOW - 1) : 7'(TX_HALF_FAST - 1); // [R6]
      s_d.tx_clk = !s_q.tx_clk;
    end else begin
      s_d.tx_div = s_q.tx_div - 1'b1;
    end

    // Sample tick: ten samples per receive data clock period.
    tick = (s_q.sample_div == '0);
    if (tick) begin
      s_d.sample_div = s_q.opt.rx_rate_select ? 3'(SAMPLE_DIV_SLOW - 1) : 3'(SAMPLE_DIV_FAST - 1); // [R7] [R24]
    end else begin
      s_d.sample_div = s_q.sample_div - 1'b1;
    end

    if (fifo_in_valid && fifo_in_ready) begin
      s_d.pend_v[fifo_in_data.id] = 1'b0;
    end

    for (int r = 0; r < 2; r++) begin
      hi_one = top_settled(s_q.rx[r].one_sr); // [R10]
      hi_zero = top_settled(s_q.rx[r].zero_sr);
      lo_null = low_settled(s_q.rx[r].null_sr);
      gap_null = top_settled(s_q.rx[r].null_sr) && lo_null; // [R12]
      bit_ok = tick && (hi_one || hi_zero) && lo_null; // [R11]
      accept = 1'b0;
      w = s_q.rx[r].shift;

      if (tick) begin
        s_d.rx[r].one_sr = {s_q.rx[r].one_sr[SR_W-2:0], line_in[r].one_lvl};
        s_d.rx[r].zero_sr = {s_q.rx[r].zero_sr[SR_W-2:0], line_in[r].zero_lvl};
        s_d.rx[r].null_sr = {s_q.rx[r].null_sr[SR_W-2:0], !line_in[r].one_lvl && !line_in[r].zero_lvl};
        if (s_q.rx[r].space_cnt != '1) begin
          s_d.rx[r].space_cnt = s_q.rx[r].space_cnt + 1'b1;
        end
      end
      // A consumed bit empties the one and zero samplers but for the newest sample; the null sampler is kept.
      if (bit_ok) begin
        s_d.rx[r].one_sr &= SR_W'(1);
        s_d.rx[r].zero_sr &= SR_W'(1);
        s_d.rx[r].space_cnt = 5'h1;
      end

      unique case (s_q.rx[r].phase)
        RX_WAIT_GAP: begin
          if (tick && gap_null) begin
            s_d.rx[r].phase = RX_BITS; // [R12]
            s_d.rx[r].bit_cnt = '0;
          end
        end
        RX_BITS: begin
          if (bit_ok) begin
            if (s_q.rx[r].bit_cnt != '0 && s_q.rx[r].space_cnt < 5'(SPACE_MIN)) begin
              s_d.rx[r].phase = RX_WAIT_GAP; // [R13]
            end else begin
              w[s_q.rx[r].bit_cnt[4:0]] = hi_one; // [R8]
              s_d.rx[r].shift = w;
              s_d.rx[r].bit_cnt = s_q.rx[r].bit_cnt + 1'b1;
              if (s_q.rx[r].bit_cnt == 6'(WORD_BITS - 1)) begin
                w[PARITY_IDX] = ~^w; // [R15]
                s_d.rx[r].shift = w;
                s_d.event_pulse[r] = 1'b1; // [R16]
                if (r == 0) begin
                  accept = !s_q.opt.rx_one_filter_enable ||
                           (w[LABEL_BIT9_IDX] == s_q.opt.rx_one_label_bit9 &&
                            w[LABEL_BIT10_IDX] == s_q.opt.rx_one_label_bit10); // [R3]
                end else begin
                  accept = !s_q.opt.rx_two_filter_enable ||
                           (w[LABEL_BIT9_IDX] == s_q.opt.rx_two_label_bit9 &&
                            w[LABEL_BIT10_IDX] == s_q.opt.rx_two_label_bit10); // [R4]
                end
                s_d.rx[r].phase = RX_GAP_TIMER;
                s_d.rx[r].gap_div = s_q.opt.rx_rate_select ? 7'(DATA_DIV_SLOW - 1) : 7'(DATA_DIV_FAST - 1);
                s_d.rx[r].gap_nulls = '0;
              end
            end
          end else if (tick && s_q.rx[r].bit_cnt != '0 && s_q.rx[r].space_cnt >= 5'(SPACE_MAX)) begin
            s_d.rx[r].phase = RX_WAIT_GAP; // [R13]
          end
        end
        RX_GAP_TIMER: begin
          if (s_q.rx[r].gap_div == '0) begin
            s_d.rx[r].gap_div = s_q.opt.rx_rate_select ? 7'(DATA_DIV_SLOW - 1) : 7'(DATA_DIV_FAST - 1); // [R14]
            if (s_q.rx[r].null_sr[0]) begin
              s_d.rx[r].gap_nulls = s_q.rx[r].gap_nulls + 1'b1;
              if (s_q.rx[r].gap_nulls == 2'(GAP_NULLS - 1)) begin
                s_d.rx[r].phase = RX_BITS; // [R14]
                s_d.rx[r].bit_cnt = '0;
                s_d.rx[r].gap_nulls = '0;
              end
            end else begin
              s_d.rx[r].gap_nulls = '0;
            end
          end else begin
            s_d.rx[r].gap_div = s_q.rx[r].gap_div - 1'b1;
          end
        end
        default: begin
          s_d.rx[r].phase = RX_WAIT_GAP;
        end
      endcase

      // A new word replaces one still waiting for the buffer.
      if (accept) begin
        s_d.pend_v[r] = 1'b1; // [R16]
        s_d.pend_w[r] = w;
      end

      // Holding word and host read tracking.
      s_d.hold[r].strobe_low = strobe_low[r];
      if (strobe_low[r]) begin
        s_d.hold[r].sel_seen = byte_select;
      end
      done = s_q.hold[r].strobe_low && !strobe_low[r];
      if (done && !s_q.hold[r].ready_n) begin
        s_d.hold[r].halves[s_q.hold[r].sel_seen] = 1'b1; // [R17]
      end
      if (&s_d.hold[r].halves) begin
        s_d.hold[r].ready_n = 1'b1; // [R17]
        s_d.hold[r].halves = '0;
      end
      if (fifo_out_valid && fifo_out_ready && fifo_out_data.id == 1'(r)) begin
        s_d.hold[r].word = fifo_out_data.data; // [R19] [R23]
        s_d.hold[r].ready_n = 1'b0; // [R16]
        s_d.hold[r].halves = '0;
      end
    end

    // Registered bus drive for the strobe that is active.
    s_d.bus_oe = |strobe_low;
    if (strobe_low[0]) begin
      s_d.bus_out = bus_half(s_q.hold[0].word, byte_select); // [R18] [R23]
    end else if (strobe_low[1]) begin
      s_d.bus_out = bus_half(s_q.hold[1].word, byte_select); // [R22]
    end else begin
      s_d.bus_out = '0;
    end

    // Master reset stops reception, clears words and flags and restarts the transmit clock; options are kept.
    if (!master_reset_n) begin
      s_d.rx = '0; // [R21]
      s_d.pend_v = '0;
      s_d.pend_w = '0;
      s_d.event_pulse = '0;
      s_d.tx_div = '0;
      s_d.tx_clk = 1'b0;
      for (int r = 0; r < 2; r++) begin
        s_d.hold[r].word = '0;
        s_d.hold[r].ready_n = 1'b1;
        s_d.hold[r].halves = '0;
      end
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.opt <= option_t'(OPTION_RESET);
      s_q.hold[0].ready_n <= 1'b1;
      s_q.hold[1].ready_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign bus_out = s_q.bus_out;
  assign bus_oe = s_q.bus_oe;
  assign rx_one_word_ready_n = s_q.hold[0].ready_n;
  assign rx_two_word_ready_n = s_q.hold[1].ready_n;
  assign word_complete_event = s_q.event_pulse;
  assign tx_data_clk = s_q.tx_clk;
  assign tx_parity_even = s_q.opt.parity_sense_bit; // [R5]

endmodule

// File: tb/arinc_dual_rx_chk.sv
// Concurrent checks on the host-side ports of the dual serial receiver.
module arinc_dual_rx_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic master_reset_n,
  input wire logic option_word_strobe,
  input wire logic [arinc_rx_pkg::BUS_W-1:0] bus_in,
  input wire logic [arinc_rx_pkg::BUS_W-1:0] bus_out,
  input wire logic bus_oe,
  input wire logic rx_one_read_strobe_n,
  input wire logic rx_two_read_strobe_n,
  input wire logic rx_one_word_ready_n,
  input wire logic rx_two_word_ready_n,
  input wire logic [1:0] word_complete_event,
  input wire logic tx_parity_even
);
  import arinc_rx_pkg::*;

  // ==========================================================================
  // Cycles since the last end-of-word event, saturating
  // ==========================================================================
  logic [9:0] since_one_q;
  logic [9:0] since_two_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_one_q <= 10'h3ff;
      since_two_q <= 10'h3ff;
    end else begin
      since_one_q <= word_complete_event[0] ? 10'h000 : since_one_q + {9'h000, since_one_q != 10'h3ff};
      since_two_q <= word_complete_event[1] ? 10'h000 : since_two_q + {9'h000, since_two_q != 10'h3ff};
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_parity_copy: assert property (option_word_strobe ##1 !option_word_strobe |=>
    tx_parity_even == $past(bus_in[12], 2)) else $error("parity sense not taken from bus");
  a_drive_track: assert property (bus_oe == $past(!rx_one_read_strobe_n || !rx_two_read_strobe_n))
    else $error("bus drive does not follow the read strobes");
  a_idle_bus: assert property (!bus_oe |-> bus_out == 16'h0000) else $error("bus data while not driving");
  a_ready_release: assert property ($rose(rx_one_word_ready_n) |-> !$past(master_reset_n) ||
    !$past(master_reset_n, 2) || !$past(rx_one_read_strobe_n, 2) || !$past(rx_one_read_strobe_n, 3))
    else $error("ready one freed without a read");
  a_ready_one_cause: assert property ($fell(rx_one_word_ready_n) |-> since_one_q < 10'h010)
    else $error("ready one set without a word");
  a_ready_two_cause: assert property ($fell(rx_two_word_ready_n) |-> since_two_q < 10'h010)
    else $error("ready two set without a word");
  a_event_pulse: assert property (|word_complete_event |=> (word_complete_event & $past(word_complete_event)) == 2'h0)
    else $error("end-of-word event longer than one cycle");
  a_word_spacing: assert property (word_complete_event[0] |-> since_one_q >= 10'h0f0)
    else $error("words closer than the minimum bit spacing allows");
  a_reset_clears: assert property (!master_reset_n |=> rx_one_word_ready_n && rx_two_word_ready_n &&
    word_complete_event == 2'h0) else $error("master reset left a word pending");

  c_word_one: cover property ($fell(rx_one_word_ready_n));
  c_word_two: cover property ($fell(rx_two_word_ready_n));
  c_both_strobes: cover property (!rx_one_read_strobe_n && !rx_two_read_strobe_n);
endmodule

bind arinc_dual_rx arinc_dual_rx_chk u_chk (.clk(clk), .arst_n(arst_n), .master_reset_n(master_reset_n),
  .option_word_strobe(option_word_strobe), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
  .rx_one_read_strobe_n(rx_one_read_strobe_n), .rx_two_read_strobe_n(rx_two_read_strobe_n),
  .rx_one_word_ready_n(rx_one_word_ready_n), .rx_two_word_ready_n(rx_two_word_ready_n),
  .word_complete_event(word_complete_event), .tx_parity_even(tx_parity_even));

// File: tb/line_source.sv
// Serial line model that sends return-to-zero words on one receiver input.
module line_source (
  input wire logic clk,
  output arinc_rx_pkg::line_t line
);
  timeunit 1ns;
  timeprecision 1ps;
  import arinc_rx_pkg::*;

  // The line rests at null between words.
  initial line = '0;

  // Each bit is a pulse of hi cycles then a null of lo cycles, lowest bit first.
  task automatic send(input logic [WORD_BITS-1:0] w, input int hi, input int lo);
    for (int n = 0; n < WORD_BITS; n++) begin
      @(posedge clk);
      line <= {w[n], !w[n]};
      repeat (hi) @(posedge clk);
      line <= '0;
      repeat (lo - 1) @(posedge clk);
    end
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the dual serial receiver through its host bus.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import arinc_rx_pkg::*;

  // ==========================================================================
  // Signals and instances
  // ==========================================================================
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic master_reset_n = 1'b1;
  logic option_word_strobe = 1'b0;
  logic byte_select = 1'b0;
  logic [1:0] rd_n = 2'h3;
  logic [BUS_W-1:0] host_bus = '0;
  logic [BUS_W-1:0] bus_out;
  logic bus_oe;
  logic [1:0] ev;
  logic tx_clk;
  logic tx_prev;
  logic par_even;
  wire [1:0] rdy_n;
  wire [BUS_W-1:0] bus_in = bus_oe ? bus_out : host_bus;
  line_t line1;
  line_t line2;
  line_t line_tx;
  int mismatches = 0;
  int n_tests = 0;
  int ev_cnt[2] = '{0, 0};
  logic [31:0] words[4] = '{32'h0000_0001, 32'h8000_0001, 32'h7ace_1357, 32'h1b2d_3c4e};

  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    tx_prev <= tx_clk;
    for (int i = 0; i < 2; i++) ev_cnt[i] += int'(ev[i] === 1'b1);
  end

  arinc_dual_rx i_arinc_dual_rx (.clk(clk), .arst_n(arst_n), .master_reset_n(master_reset_n),
    .option_word_strobe(option_word_strobe), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .byte_select(byte_select), .rx_one_read_strobe_n(rd_n[0]), .rx_two_read_strobe_n(rd_n[1]),
    .rx_one_word_ready_n(rdy_n[0]), .rx_two_word_ready_n(rdy_n[1]), .word_complete_event(ev),
    .rx_one_line(line1), .rx_two_line(line2), .tx_serial_line_out(line_tx), .tx_data_clk(tx_clk),
    .tx_parity_even(par_even));
  line_source u_src1 (.clk(clk), .line(line1));
  line_source u_src2 (.clk(clk), .line(line2));
  line_source u_srct (.clk(clk), .line(line_tx));

  // ==========================================================================
  // Compare, report and bus tasks
  // ==========================================================================
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_word(what, {31'h0000_0000, exp}, {31'h0000_0000, got});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic set_opt(input option_t o);
    @(posedge clk);
    option_word_strobe <= 1'b1;
    host_bus <= {1'b0, o, 5'h00};
    @(posedge clk);
    option_word_strobe <= 1'b0;
    host_bus <= ~host_bus;
  endtask

  // Holds the strobes low until the device drives the bus, then takes the data.
  task automatic rd(input logic [1:0] mask, input logic sel, output logic [15:0] d);
    int i;
    @(posedge clk);
    rd_n <= ~mask;
    byte_select <= sel;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (bus_oe === 1'b1) break;
    end
    chk_bit("bus drive", 1'b1, bus_oe);
    if (bus_oe !== 1'b1) wrap_up();
    d = bus_out;
    rd_n <= 2'h3;
    @(posedge clk);
  endtask

  function automatic logic [31:0] halves(input logic [31:0] w);
    logic [31:0] s;
    s = w;
    s[31] = ~^w;
    return {s[28:13], s[12:8], s[30], s[29], s[31], s[0], s[1], s[2], s[3], s[4], s[5], s[6], s[7]};
  endfunction

  task automatic get_word(input int rx, input logic [31:0] w, input logic first);
    logic [15:0] ha;
    logic [15:0] hb;
    rd(2'(rx + 1), first, ha);
    chk_bit("ready held", 1'b0, rdy_n[rx]);
    rd(2'(rx + 1), !first, hb);
    cyc(3);
    chk_bit("ready freed", 1'b1, rdy_n[rx]);
    chk_word("word", halves(w), first ? {ha, hb} : {hb, ha});
  endtask

  // Sends a word after a word gap; rx 2 drives the transmitter outputs in loopback.
  task automatic put(input int rx, input logic [31:0] w, input int hi = 5, input int lo = 5);
    cyc(6 * (hi + lo));
    case (rx)
      0: u_src1.send(w, hi, lo);
      1: u_src2.send(w, hi, lo);
      default: fork
        u_srct.send(w, hi, lo);
        u_src1.send(~w, hi, lo);
      join
    endcase
    cyc(20);
  endtask

  task automatic tx_period(output int p);
    int rises;
    rises = 0;
    p = 0;
    for (int n = 0; n < 400; n++) begin
      @(posedge clk);
      if (tx_clk === 1'b1 && tx_prev === 1'b0) rises++;
      if (rises == 3) break;
      if (rises == 2) p++;
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    option_t o;
    logic [15:0] d;
    logic [31:0] x;
    int k;
    int e;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    cyc(2);
    chk_bit("ready one", 1'b1, rdy_n[0]);
    chk_bit("ready two", 1'b1, rdy_n[1]);
    o = option_t'(OPTION_RESET);
    o.parity_sense_bit = 1'b1;
    set_opt(o);
    cyc(2);
    chk_bit("parity sense", 1'b1, par_even);
    for (k = 0; k < 2; k++) begin
      o.tx_rate_select = k[0];
      set_opt(o);
      tx_period(e);
      chk_word("tx clock period", k ? 32'h0000_0050 : 32'h0000_000a, 32'(e));
    end
    for (k = 0; k < 4; k++) begin
      put(k % 2, words[k]);
      get_word(k % 2, words[k], k[1]);
    end
    for (k = 0; k < 2; k++) begin
      o.rx_one_filter_enable = (k == 0);
      o.rx_one_label_bit9 = 1'b1;
      o.rx_two_filter_enable = (k == 1);
      o.rx_two_label_bit9 = 1'b1;
      set_opt(o);
      e = ev_cnt[k];
      put(k, 32'h0000_0200);
      chk_word("events", 32'(e + 1), 32'(ev_cnt[k]));
      chk_bit("filtered", 1'b1, rdy_n[k]);
      put(k, 32'h0000_0100);
      get_word(k, 32'h0000_0100, 1'b0);
    end
    o.rx_two_filter_enable = 1'b0;
    set_opt(o);
    put(0, words[2]);
    put(0, words[3]);
    get_word(0, words[3], 1'b0);
    for (k = 3; k < 8; k += 4) begin
      put(0, words[2], k, k);
      chk_bit("bad spacing", 1'b1, rdy_n[0]);
    end
    put(0, words[1]);
    get_word(0, words[1], 1'b1);
    o.loopback_test_bit = 1'b0;
    set_opt(o);
    put(2, words[2]);
    get_word(0, words[2], 1'b0);
    get_word(1, ~words[2], 1'b1);
    o.loopback_test_bit = 1'b1;
    set_opt(o);
    put(0, words[3]);
    master_reset_n <= 1'b0;
    cyc(2);
    master_reset_n <= 1'b1;
    cyc(2);
    chk_bit("reset ready", 1'b1, rdy_n[0]);
    chk_bit("options kept", 1'b1, par_even);
    put(0, words[2]);
    put(1, words[3]);
    x = halves(words[2]);
    rd(2'h3, 1'b0, d);
    chk_word("shared bus", {16'h0000, x[15:0]}, {16'h0000, d});
    rd(2'h1, 1'b1, d);
    cyc(3);
    chk_bit("ready one read", 1'b1, rdy_n[0]);
    chk_bit("ready two kept", 1'b0, rdy_n[1]);
    get_word(1, words[3], 1'b1);
    o.rx_rate_select = 1'b1;
    set_opt(o);
    put(1, words[2], 40, 40);
    get_word(1, words[2], 1'b0);
    wrap_up();
  end
endmodule
